// ==== verilog/ace_match_cfg.svh ====
/*
  Register offsets, field positions, reset values and widths of the
  access control entry matcher.
  Assumes inclusion by bare name from the package and the matcher module.
*/
`ifndef ACE_MATCH_CFG_SVH
`define ACE_MATCH_CFG_SVH

`define ADDR_W 8
`define DATA_W 32
`define PORT_W 16

`define OFS_CTRL 8'h00
`define OFS_SRC_LO 8'h04
`define OFS_SRC_HI 8'h08
`define OFS_DST_LO 8'h0C
`define OFS_DST_HI 8'h10
`define OFS_FLAGS 8'h14
`define OFS_ETYPE 8'h18
`define OFS_STATUS 8'h1C

`define CTRL_SRC_LSB 0
`define CTRL_DST_LSB 2
`define CTRL_FTYPE_BIT 4
`define CTRL_ETMODE_BIT 5

`define CTRL_RST 6'h00
`define PORT_LO_RST 16'h0000
`define PORT_HI_RST 16'hFFFF
`define FLAGS_RST 12'h000
`define ETYPE_RST 16'h0600

`define ETYPE_MIN 16'h0600
`define ETYPE_IPV4 16'h0800
`define ETYPE_ARP 16'h0806
`define ETYPE_IPV6 16'h86DD

`endif

// ==== verilog/ace_match_pkg.sv ====
/*
  Types shared by the access control entry matcher and its bench.
  Assumes the configuration header is on the include path.
*/
`default_nettype none
`include "ace_match_cfg.svh"

package ace_match_pkg;

  typedef enum logic [1:0] {
    PORT_ANY = 2'b00,
    PORT_SPECIFIC = 2'b01,
    PORT_RANGE = 2'b10
  } port_mode_t;

  typedef enum logic [1:0] {
    FLAG_ANY = 2'b00,
    FLAG_CLEAR = 2'b01,
    FLAG_SET = 2'b10
  } flag_cond_t;

  // Flag order in the flag vector and in the flag register, two bits each.
  typedef enum logic [2:0] {
    TCP_FIN = 3'h0,
    TCP_SYN = 3'h1,
    TCP_RST = 3'h2,
    TCP_PSH = 3'h3,
    TCP_ACK = 3'h4,
    TCP_URG = 3'h5
  } tcp_flag_idx_t;

  typedef struct packed {
    logic valid;
    logic [15:0] ether_type;
    logic is_tcp;
    logic is_udp;
    logic [15:0] src_port;
    logic [15:0] dst_port;
    logic [5:0] tcp_flags;
  } frame_t;

  typedef struct packed {
    logic valid;
    logic hit;
  } verdict_t;

endpackage : ace_match_pkg

`default_nettype wire

// ==== verilog/l4_ethertype_ace_matcher.sv ====
/*
  Match logic for one access_control_entry: layer-4 port filters, six TCP
  flag conditions and an EtherType filter, configured over a plain
  register port, with a one-cycle registered verdict per frame.
  Assumes frame header fields are already parsed and synchronous to
  sys_clk_i, and a register master that never issues read and write at once.
*/
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ace_match_cfg.svh"

module l4_ethertype_ace_matcher (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [`ADDR_W-1:0] reg_addr_i,
  input wire logic [`DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`DATA_W-1:0] reg_rdata_o,
  input wire ace_match_pkg::frame_t frame_i,
  output ace_match_pkg::verdict_t verdict_o
);
  import ace_match_pkg::*;

  logic [5:0] ctrl_r;
  logic [15:0] src_lo_r;
  logic [15:0] src_hi_r;
  logic [15:0] dst_lo_r;
  logic [15:0] dst_hi_r;
  logic [11:0] flags_r;
  logic [15:0] etype_r;
  logic etype_rej_r;
  logic [15:0] hit_cnt_r;
  logic [`DATA_W-1:0] rdata_nxt;
  logic etype_wr_ok;
  port_mode_t src_mode;
  port_mode_t dst_mode;
  logic ftype_eth;
  logic etmode_spec;
  logic src_ok;
  logic dst_ok;
  logic [5:0] flag_ok;
  logic flags_all_ok;
  logic etype_ok;
  logic hit_nxt;

  // Mode 2'b11 is not a legal code; it is decoded as don't-care.
  function automatic logic port_match(input logic [1:0] mode,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi,
                                      input logic [15:0] port);
    logic res;
    res = 1'b1;
    if (mode == PORT_SPECIFIC) begin
      res = (port == lo);
    end else if (mode == PORT_RANGE) begin
      res = (port >= lo) && (port <= hi);
    end
    return res;
  endfunction : port_match

  function automatic logic etype_legal(input logic [15:0] val);
    return (val >= `ETYPE_MIN) && (val != `ETYPE_IPV4) &&
           (val != `ETYPE_ARP) && (val != `ETYPE_IPV6);
  endfunction : etype_legal

  assign src_mode = port_mode_t'(ctrl_r[`CTRL_SRC_LSB +: 2]);
  assign dst_mode = port_mode_t'(ctrl_r[`CTRL_DST_LSB +: 2]);
  assign ftype_eth = ctrl_r[`CTRL_FTYPE_BIT];
  assign etmode_spec = ctrl_r[`CTRL_ETMODE_BIT];
  assign etype_wr_ok = etype_legal(reg_wdata_i[15:0]);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_r <= `CTRL_RST;
    end else if (reg_wr_i && reg_addr_i == `OFS_CTRL) begin
      ctrl_r <= reg_wdata_i[5:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      src_lo_r <= `PORT_LO_RST;
      src_hi_r <= `PORT_HI_RST;
      dst_lo_r <= `PORT_LO_RST;
      dst_hi_r <= `PORT_HI_RST;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `OFS_SRC_LO: src_lo_r <= reg_wdata_i[15:0];
        `OFS_SRC_HI: src_hi_r <= reg_wdata_i[15:0];
        `OFS_DST_LO: dst_lo_r <= reg_wdata_i[15:0];
        `OFS_DST_HI: dst_hi_r <= reg_wdata_i[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      flags_r <= `FLAGS_RST;
    end else if (reg_wr_i && reg_addr_i == `OFS_FLAGS) begin
      flags_r <= reg_wdata_i[11:0];
    end
  end

  // An illegal type code leaves the previous value in force, so a bad
  // write can never open the entry to IP or ARP traffic.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      etype_r <= `ETYPE_RST;
      etype_rej_r <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == `OFS_ETYPE) begin
      if (etype_wr_ok) begin
        etype_r <= reg_wdata_i[15:0];
        etype_rej_r <= 1'b0;
      end else begin
        etype_rej_r <= 1'b1;
      end
    end
  end

  assign src_ok = port_match(src_mode, src_lo_r, src_hi_r,
                             frame_i.src_port);
  assign dst_ok = port_match(dst_mode, dst_lo_r, dst_hi_r,
                             frame_i.dst_port);

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_flag
      logic [1:0] cond;
      assign cond = flags_r[2*gi +: 2];
      always_comb begin
        flag_ok[gi] = 1'b1;
        if (cond == FLAG_CLEAR) begin
          flag_ok[gi] = frame_i.is_tcp && !frame_i.tcp_flags[gi];
        end else if (cond == FLAG_SET) begin
          flag_ok[gi] = frame_i.is_tcp && frame_i.tcp_flags[gi];
        end
      end
    end
  endgenerate

  assign flags_all_ok = &flag_ok;

  assign etype_ok = !ftype_eth || !etmode_spec ||
                    (frame_i.ether_type == etype_r);

  // Port filters need a transport header; a frame without one cannot
  // satisfy an enabled port filter.
  always_comb begin
    hit_nxt = src_ok && dst_ok && flags_all_ok && etype_ok;
    if ((src_mode inside {PORT_SPECIFIC, PORT_RANGE} ||
         dst_mode inside {PORT_SPECIFIC, PORT_RANGE}) &&
        !(frame_i.is_tcp || frame_i.is_udp)) begin
      hit_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      verdict_o <= '0;
    end else begin
      verdict_o.valid <= frame_i.valid;
      verdict_o.hit <= frame_i.valid && hit_nxt;
    end
  end

  // The counter wraps; software takes differences between reads.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      hit_cnt_r <= 16'h0000;
    end else if (frame_i.valid && hit_nxt) begin
      hit_cnt_r <= hit_cnt_r + 16'h0001;
    end
  end

  always_comb begin
    rdata_nxt = '0;
    unique case (reg_addr_i)
      `OFS_CTRL: rdata_nxt = {26'h0000000, ctrl_r};
      `OFS_SRC_LO: rdata_nxt = {16'h0000, src_lo_r};
      `OFS_SRC_HI: rdata_nxt = {16'h0000, src_hi_r};
      `OFS_DST_LO: rdata_nxt = {16'h0000, dst_lo_r};
      `OFS_DST_HI: rdata_nxt = {16'h0000, dst_hi_r};
      `OFS_FLAGS: rdata_nxt = {20'h00000, flags_r};
      `OFS_ETYPE: rdata_nxt = {16'h0000, etype_r};
      `OFS_STATUS: rdata_nxt = {hit_cnt_r, 14'h0000, etype_rej_r,
                                verdict_o.hit};
      default: rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end else begin
      reg_rdata_o <= '0;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  AST_SRC_SPEC_MISS: assert property (
    frame_i.valid && src_mode == PORT_SPECIFIC &&
    frame_i.src_port != src_lo_r |=> !verdict_o.hit)
    else $error("Specific source mismatch produced a hit.");

  AST_SRC_RANGE_OUT: assert property (
    frame_i.valid && src_mode == PORT_RANGE &&
    (frame_i.src_port < src_lo_r || frame_i.src_port > src_hi_r)
    |=> !verdict_o.hit)
    else $error("Source port outside range produced a hit.");

  AST_DST_SPEC_MISS: assert property (
    frame_i.valid && dst_mode == PORT_SPECIFIC &&
    frame_i.dst_port != dst_lo_r |=> !verdict_o.hit)
    else $error("Specific destination mismatch produced a hit.");

  AST_DST_RANGE_OUT: assert property (
    frame_i.valid && dst_mode == PORT_RANGE &&
    (frame_i.dst_port < dst_lo_r || frame_i.dst_port > dst_hi_r)
    |=> !verdict_o.hit)
    else $error("Destination port outside range produced a hit.");

  AST_FIN_CLEAR: assert property (
    frame_i.valid && flags_r[1:0] == FLAG_CLEAR && frame_i.is_tcp &&
    frame_i.tcp_flags[TCP_FIN] |=> !verdict_o.hit)
    else $error("Frame with FIN set hit a require-clear entry.");

  AST_URG_SET: assert property (
    frame_i.valid && flags_r[11:10] == FLAG_SET &&
    !frame_i.tcp_flags[TCP_URG] |=> !verdict_o.hit)
    else $error("Frame without URG hit a require-set entry.");

  AST_ETYPE_MISS: assert property (
    frame_i.valid && ftype_eth && etmode_spec &&
    frame_i.ether_type != etype_r |=> !verdict_o.hit)
    else $error("EtherType mismatch produced a hit.");

  AST_ETYPE_REJECT: assert property (
    reg_wr_i && reg_addr_i == `OFS_ETYPE && !etype_wr_ok
    |=> $stable(etype_r) && etype_rej_r)
    else $error("Forbidden EtherType value was stored.");

  AST_NO_L4_HDR: assert property (
    frame_i.valid && src_mode inside {PORT_SPECIFIC, PORT_RANGE} &&
    !frame_i.is_tcp && !frame_i.is_udp |=> !verdict_o.hit)
    else $error("Frame without transport header hit a port filter.");

  AST_ALL_ANY_HIT: assert property (
    frame_i.valid && src_mode == PORT_ANY && dst_mode == PORT_ANY &&
    flags_r == `FLAGS_RST && !ftype_eth |=> verdict_o.hit)
    else $error("Entry with every filter at any failed to hit.");

  AST_RDATA_ONE_CYCLE: assert property (
    !reg_rd_i |=> reg_rdata_o == '0)
    else $error("Read data stood outside the read answer cycle.");

  // The hit checks below hold every other filter at any, so a miss can
  // only come from the filter under test.
  AST_SRC_RANGE_HIT: assert property (
    frame_i.valid && (frame_i.is_tcp || frame_i.is_udp) &&
    src_mode == PORT_RANGE && dst_mode == PORT_ANY &&
    flags_r == `FLAGS_RST && !ftype_eth &&
    frame_i.src_port >= src_lo_r && frame_i.src_port <= src_hi_r
    |=> verdict_o.hit)
    else $error("Source port inside range failed to hit.");

  AST_DST_SPEC_HIT: assert property (
    frame_i.valid && (frame_i.is_tcp || frame_i.is_udp) &&
    src_mode == PORT_ANY && dst_mode == PORT_SPECIFIC &&
    flags_r == `FLAGS_RST && !ftype_eth &&
    frame_i.dst_port == dst_lo_r |=> verdict_o.hit)
    else $error("Matching destination port failed to hit.");

  AST_DST_RANGE_HIT: assert property (
    frame_i.valid && (frame_i.is_tcp || frame_i.is_udp) &&
    src_mode == PORT_ANY && dst_mode == PORT_RANGE &&
    flags_r == `FLAGS_RST && !ftype_eth &&
    frame_i.dst_port >= dst_lo_r && frame_i.dst_port <= dst_hi_r
    |=> verdict_o.hit)
    else $error("Destination port inside range failed to hit.");

  AST_URG_SET_HIT: assert property (
    frame_i.valid && frame_i.is_tcp && frame_i.tcp_flags[TCP_URG] &&
    src_mode == PORT_ANY && dst_mode == PORT_ANY &&
    flags_r == 12'h800 && !ftype_eth |=> verdict_o.hit)
    else $error("Frame with URG set missed a require-set entry.");

  AST_FLAG_NEEDS_TCP: assert property (
    frame_i.valid && !frame_i.is_tcp && flags_r[11:10] == FLAG_SET
    |=> !verdict_o.hit)
    else $error("Non-TCP frame hit an entry with a flag condition.");

  AST_ETYPE_ANY_HIT: assert property (
    frame_i.valid && ftype_eth && !etmode_spec &&
    src_mode == PORT_ANY && dst_mode == PORT_ANY &&
    flags_r == `FLAGS_RST |=> verdict_o.hit)
    else $error("EtherType filter at any blocked a frame.");

  AST_ETYPE_OFF_FTYPE: assert property (
    frame_i.valid && !ftype_eth && etmode_spec &&
    src_mode == PORT_ANY && dst_mode == PORT_ANY &&
    flags_r == `FLAGS_RST |=> verdict_o.hit)
    else $error("EtherType filter applied outside Ethernet-type frames.");

  AST_ETYPE_MATCH_HIT: assert property (
    frame_i.valid && ftype_eth && etmode_spec &&
    frame_i.ether_type == etype_r && src_mode == PORT_ANY &&
    dst_mode == PORT_ANY && flags_r == `FLAGS_RST |=> verdict_o.hit)
    else $error("Matching EtherType failed to hit.");

  // The verdict is a pure one-cycle image of the frame strobe.
  AST_VERDICT_FOLLOWS: assert property (
    verdict_o.valid == $past(frame_i.valid) &&
    (!verdict_o.hit || verdict_o.valid))
    else $error("Verdict did not follow its frame by one cycle.");

  AST_HIT_COUNT: assert property (
    verdict_o.hit |-> hit_cnt_r == $past(hit_cnt_r) + 16'h0001)
    else $error("Hit counter did not advance with a hit verdict.");

  COV_RANGE_HIT: cover property (
    frame_i.valid && src_mode == PORT_RANGE ##1 verdict_o.hit);
  COV_FLAG_SET_HIT: cover property (
    frame_i.valid && flags_r[3:2] == FLAG_SET ##1 verdict_o.hit);
  COV_ETYPE_HIT: cover property (
    frame_i.valid && ftype_eth && etmode_spec ##1 verdict_o.hit);
  COV_ETYPE_REJ: cover property (
    reg_wr_i && reg_addr_i == `OFS_ETYPE && !etype_wr_ok);
  COV_MODE3_ANY_HIT: cover property (
    frame_i.valid && ctrl_r[1:0] == 2'b11 ##1 verdict_o.hit);

endmodule : l4_ethertype_ace_matcher

`default_nettype wire

// ==== sim/frame_feed.sv ====
/*
  Frame source standing in for the switch ports: presents one parsed
  header for one cycle per call.
  Assumes the caller runs on the matcher clock.
*/
`timescale 1ns/10ps
`default_nettype none
module frame_feed (
  input wire logic clk_i,
  output var ace_match_pkg::frame_t frame_o
);
  import ace_match_pkg::*;
  initial frame_o = '0;
  // Released fields are inverted so a stale header never matches by luck.
  task automatic send(input logic [15:0] et, input logic [1:0] kind,
      input logic [15:0] sp, input logic [15:0] dp, input logic [5:0] fl);
    @(posedge clk_i);
    frame_o <= {1'b1, et, kind, sp, dp, fl};
    @(posedge clk_i);
    frame_o <= {1'b0, ~et, ~kind, ~sp, ~dp, ~fl};
  endtask : send
endmodule : frame_feed
`default_nettype wire

// ==== sim/l4_ethertype_ace_matcher_tb_top.sv ====
/*
  Self-checking bench of the entry matcher: register port tasks, frame
  scenarios through the frame source, one verdict per frame.
  Assumes the configuration header is on the include path.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ace_match_cfg.svh"
module l4_ethertype_ace_matcher_tb_top;
  import ace_match_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] v;
  frame_t frame_w;
  verdict_t verdict_w;
  int err_total = 0;
  int cmp_count = 0;
  always #20 sys_clk_i = ~sys_clk_i;
  frame_feed frame_feed_inst (.clk_i(sys_clk_i), .frame_o(frame_w));
  l4_ethertype_ace_matcher l4_ethertype_ace_matcher_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .frame_i(frame_w), .verdict_o(verdict_w));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    rd <= 1'b1; addr <= a;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  // Kind is {tcp, udp}; the verdict must stand in the cycle after the frame.
  task automatic fr(input logic [15:0] et, input logic [1:0] kind,
      input logic [15:0] sp, input logic [15:0] dp, input logic [5:0] fl,
      input logic exp);
    frame_feed_inst.send(et, kind, sp, dp, fl);
    #1 chk({30'h0, verdict_w.valid, verdict_w.hit}, {30'h0, 1'b1, exp});
  endtask : fr
  task automatic t_reset;
    rreg(`OFS_CTRL, v);
    chk(v, 32'h0);
    rreg(`OFS_SRC_HI, v);
    chk(v, 32'h0000FFFF);
    rreg(8'h20, v); chk(v, 32'h0);
    fr(16'h1234, 2'b00, 16'h0, 16'h0, 6'h3F, 1'b1);
    // Status bit 0 mirrors the verdict pulse, which is gone by the read.
    rreg(`OFS_STATUS, v);
    chk(v, 32'h00010000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_ports;
    wreg(`OFS_SRC_LO, 32'h1234); wreg(`OFS_CTRL, 32'h1);
    fr(16'h0, 2'b10, 16'h1234, 16'h7, 6'h0, 1'b1);
    fr(16'h0, 2'b01, 16'h1235, 16'h7, 6'h0, 1'b0);
    fr(16'h0, 2'b00, 16'h1234, 16'h7, 6'h0, 1'b0);
    wreg(`OFS_SRC_LO, 32'hA); wreg(`OFS_SRC_HI, 32'h14);
    wreg(`OFS_CTRL, 32'h2);
    fr(16'h0, 2'b01, 16'h14, 16'h0, 6'h0, 1'b1);
    fr(16'h0, 2'b01, 16'h15, 16'h0, 6'h0, 1'b0);
    fr(16'h0, 2'b01, 16'h9, 16'h0, 6'h0, 1'b0);
    wreg(`OFS_DST_LO, 32'hFFFF); wreg(`OFS_CTRL, 32'h4);
    fr(16'h0, 2'b10, 16'h9, 16'hFFFF, 6'h0, 1'b1);
    fr(16'h0, 2'b10, 16'h9, 16'hFFFE, 6'h0, 1'b0);
    wreg(`OFS_DST_LO, 32'h0); wreg(`OFS_DST_HI, 32'h0);
    wreg(`OFS_CTRL, 32'h8);
    fr(16'h0, 2'b10, 16'h9, 16'h0, 6'h0, 1'b1);
    fr(16'h0, 2'b10, 16'h9, 16'h1, 6'h0, 1'b0);
    wreg(`OFS_CTRL, 32'h0);
    fr(16'h0, 2'b10, 16'h9, 16'h1, 6'h0, 1'b1);
    wreg(`OFS_CTRL, 32'hF);
    fr(16'h0, 2'b00, 16'h9, 16'h1, 6'h0, 1'b1);
    wreg(`OFS_CTRL, 32'h0);
    $display("test ports done");
  endtask : t_ports
  task automatic t_flags;
    for (int i = 0; i < 6; i++) begin
      wreg(`OFS_FLAGS, 32'h1 << (2 * i));
      fr(16'h0, 2'b10, 16'h0, 16'h0, 6'h1 << i, 1'b0);
      fr(16'h0, 2'b10, 16'h0, 16'h0, ~(6'h1 << i), 1'b1);
      wreg(`OFS_FLAGS, 32'h2 << (2 * i));
      fr(16'h0, 2'b10, 16'h0, 16'h0, 6'h1 << i, 1'b1);
      fr(16'h0, 2'b10, 16'h0, 16'h0, 6'h0, 1'b0);
      fr(16'h0, 2'b01, 16'h0, 16'h0, 6'h3F, 1'b0);
    end
    wreg(`OFS_FLAGS, 32'hFFF);
    fr(16'h0, 2'b01, 16'h0, 16'h0, 6'h3F, 1'b1);
    wreg(`OFS_FLAGS, 32'h0);
    $display("test flags done");
  endtask : t_flags
  task automatic t_etype;
    logic [15:0] bad [4] = '{16'h0800, 16'h0806, 16'h86DD, 16'h05FF};
    foreach (bad[i]) begin
      wreg(`OFS_ETYPE, {16'h0, bad[i]});
      rreg(`OFS_ETYPE, v); chk(v, 32'h0600);
      rreg(`OFS_STATUS, v); chk(v & 32'h2, 32'h2);
    end
    wreg(`OFS_ETYPE, 32'hFFFF);
    rreg(`OFS_ETYPE, v); chk(v, 32'hFFFF);
    rreg(`OFS_STATUS, v);
    chk(v & 32'h2, 32'h0);
    wreg(`OFS_ETYPE, 32'h0600);
    rreg(`OFS_ETYPE, v);
    chk(v, 32'h0600);
    wreg(`OFS_ETYPE, 32'h88B5); wreg(`OFS_CTRL, 32'h30);
    fr(16'h88B5, 2'b00, 16'h0, 16'h0, 6'h0, 1'b1);
    fr(16'h88B6, 2'b00, 16'h0, 16'h0, 6'h0, 1'b0);
    wreg(`OFS_CTRL, 32'h20);
    fr(16'h88B6, 2'b00, 16'h0, 16'h0, 6'h0, 1'b1);
    wreg(`OFS_CTRL, 32'h10);
    fr(16'h88B6, 2'b00, 16'h0, 16'h0, 6'h0, 1'b1);
    $display("test etype done");
  endtask : t_etype
  // A second reset in mid-run must bring back the control, EtherType and status reset values.
  task automatic t_rerun;
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rreg(`OFS_CTRL, v);
    chk(v, 32'h0);
    rreg(`OFS_ETYPE, v);
    chk(v, 32'h0600);
    rreg(`OFS_STATUS, v);
    chk(v, 32'h0);
    fr(16'h88B6, 2'b00, 16'h0, 16'h0, 6'h0, 1'b1);
    $display("test mid-run reset done");
  endtask : t_rerun
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_ports;
    t_flags;
    t_etype;
    t_rerun;
    give_verdict;
  end
  // Every wait is a fixed count, so this only cuts a stuck run short.
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_total++;
    give_verdict;
  end
endmodule : l4_ethertype_ace_matcher_tb_top
`default_nettype wire
